// file: design/arg_pkg.sv
// Package of constants and carrier types for the converter reference and ground control
package arg_pkg;

  // ==================================================
  // Special function register map
  // ==================================================
  localparam logic [7:0] CONV_CTRL_ZERO_ADDR = 8'he8;   // Bit-addressable control register
  localparam logic [7:0] REF_CTRL_ADDR = 8'hd1;         // Reference control register
  localparam logic [7:0] CONV_CTRL_ZERO_RST = 8'h00;
  localparam logic [7:0] REF_CTRL_RST = 8'h00;

  // ==================================================
  // Field positions, converter control zero
  // ==================================================
  localparam int CONV_EN_BIT = 7;
  localparam int BURST_EN_BIT = 6;
  localparam int DONE_FLAG_BIT = 5;
  localparam int BUSY_BIT = 4;
  localparam int WIN_FLAG_BIT = 3;
  localparam int START_SEL_LSB = 0;

  // ==================================================
  // Field positions, reference control
  // ==================================================
  localparam int TEMP_EN_BIT = 0;
  localparam int GND_SEL_BIT = 1;
  localparam int REF_SEL_LSB = 3;
  localparam int IREF_LVL_BIT = 5;

  // ==================================================
  // Reference source encodings
  // ==================================================
  localparam logic [1:0] REF_EXT_PIN = 2'h0;
  localparam logic [1:0] REF_SUPPLY_PIN = 2'h1;
  localparam logic [1:0] REF_REG_1V8 = 2'h2;
  localparam logic [1:0] REF_INTERNAL = 2'h3;

  // ==================================================
  // Start source encodings
  // ==================================================
  localparam logic [2:0] START_BY_WRITE = 3'h0;
  localparam logic [2:0] START_BY_TMR0 = 3'h1;
  localparam logic [2:0] START_BY_TMR2 = 3'h2;
  localparam logic [2:0] START_BY_TMR3 = 3'h3;
  localparam logic [2:0] START_BY_PIN = 3'h4;

  // ==================================================
  // Timing
  // ==================================================
  localparam int CLK_MHZ = 40;
  localparam int REF_SETTLE_NS = 1000;                  // Internal reference wake-up time
  localparam int REF_SETTLE_CYC = (REF_SETTLE_NS * CLK_MHZ + 999) / 1000;

  // ==================================================
  // Carrier for the analog-side controls
  // ==================================================
  typedef struct packed {
    logic [1:0] ref_source;     // Selected reference source
    logic iref_power;           // Internal reference powered
    logic iref_high;            // Internal level 2.4 V when set, 1.65 V when clear
    logic gnd_analog_pin;       // Ground taken from analog ground pin
    logic gnd_chip;             // Ground forced to internal chip ground
    logic temp_sensor_on;       // Temperature sensor powered
  } arg_analog_s;

endpackage : arg_pkg

// file: design/arg_ref_ctrl.sv
// Converter reference, ground and start control with its special function registers
`timescale 1ns/100ps

module arg_ref_ctrl
#(
  parameter int SETTLE_CYC = arg_pkg::REF_SETTLE_CYC   // Internal reference wake-up cycles
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic bit_wr,
  input wire logic [7:0] bit_addr,
  input wire logic bit_val,
  input wire logic timer0_ovf,
  input wire logic timer2_ovf,
  input wire logic timer3_ovf,
  input wire logic external_start_pin,
  input wire logic temp_selected,
  input wire logic single_ended,
  input wire logic core_done,
  input wire logic core_burst_done,
  input wire logic core_tracking,
  input wire logic core_window_hit,
  output logic [7:0] sfr_rdata,
  output logic conv_start,
  output logic temp_to_positive,
  output arg_pkg::arg_analog_s analog_ctrl
);

  // ==================================================
  // Register state
  // ==================================================
  logic [7:0] conv_ctrl_reg;      // Converter control zero
  logic [7:0] ref_ctrl_reg;       // Reference control
  logic [7:0] sfr_rdata_reg;      // Read data register
  logic conv_start_reg;           // Start pulse to the core
  logic temp_pos_reg;             // Sensor routed to positive input
  arg_pkg::arg_analog_s analog_reg;
  logic pin_rise;                 // Synchronised start pin edge
  logic [15:0] settle_cnt_reg;    // Counts reference wake-up
  logic converting_reg;           // A conversion is running

  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_CONVERT} arg_state_e;
  arg_state_e state_reg;

  // Decode of write strobes, byte or bit addressed
  logic wr_conv;
  logic wr_ref;
  logic bit_conv;
  logic [2:0] bit_idx;
  assign wr_conv = sfr_wr && (sfr_addr == arg_pkg::CONV_CTRL_ZERO_ADDR);
  assign wr_ref = sfr_wr && (sfr_addr == arg_pkg::REF_CTRL_ADDR);
  // Bit addresses for a bit-addressable register are its base plus bit number
  assign bit_conv = bit_wr && (bit_addr[7:3] == arg_pkg::CONV_CTRL_ZERO_ADDR[7:3]);
  assign bit_idx = bit_addr[2:0];

  // Software view of the control register after a write this cycle
  logic [7:0] conv_wr_val;
  always_comb
  begin
    conv_wr_val = conv_ctrl_reg;
    if (wr_conv)
    begin
      conv_wr_val = sfr_wdata;
    end
    else if (bit_conv)
    begin
      conv_wr_val[bit_idx] = bit_val;
    end
  end

  // ==================================================
  // Start pin synchroniser
  // ==================================================
  arg_sync u_pin_sync
  (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(external_start_pin),
    .rise_pulse(pin_rise)
  );

  // Trigger chosen by the start source field; reserved codes start nothing
  logic [2:0] start_sel;
  logic busy_write;
  logic trigger;
  // Mode as written this cycle counts, so one write can pick the mode and start
  assign start_sel = conv_wr_val[arg_pkg::START_SEL_LSB +: 3];
  assign busy_write = (wr_conv || (bit_conv && bit_idx == 3'(arg_pkg::BUSY_BIT)))
                      && conv_wr_val[arg_pkg::BUSY_BIT];
  always_comb
  begin
    case (start_sel)
      arg_pkg::START_BY_WRITE: trigger = busy_write;
      arg_pkg::START_BY_TMR0: trigger = timer0_ovf;
      arg_pkg::START_BY_TMR2: trigger = timer2_ovf;
      arg_pkg::START_BY_TMR3: trigger = timer3_ovf;
      arg_pkg::START_BY_PIN: trigger = pin_rise;
      default: trigger = 1'b0;
    endcase
  end

  logic ref_internal;
  logic event_done;
  assign ref_internal = ref_ctrl_reg[arg_pkg::REF_SEL_LSB +: 2] == arg_pkg::REF_INTERNAL;
  // Burst mode reports once per burst, otherwise once per conversion
  assign event_done = conv_ctrl_reg[arg_pkg::BURST_EN_BIT] ? core_burst_done : core_done;
  // Trigger accepted only by an idle converter that is enabled, or in burst mode
  logic start_now;
  assign start_now = trigger && (state_reg == ST_IDLE)
                     && (conv_wr_val[arg_pkg::CONV_EN_BIT] || conv_wr_val[arg_pkg::BURST_EN_BIT]);

  // ==================================================
  // Conversion sequencer
  // ==================================================
  // Wakes the internal reference only when a conversion needs it
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      settle_cnt_reg <= 16'h0000;
      conv_start_reg <= 1'b0;
    end
    else
    begin
      conv_start_reg <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          // Disabled converter ignores triggers unless burst mode powers it per burst
          if (start_now)
          begin
            if (ref_internal)
            begin
              state_reg <= ST_SETTLE;
              settle_cnt_reg <= 16'(SETTLE_CYC);
            end
            else
            begin
              state_reg <= ST_CONVERT;
              conv_start_reg <= 1'b1;
            end
          end
        end
        ST_SETTLE:
        begin
          if (settle_cnt_reg <= 16'h0001)
          begin
            state_reg <= ST_CONVERT;
            conv_start_reg <= 1'b1;
          end
          else
          begin
            settle_cnt_reg <= settle_cnt_reg - 16'h0001;
          end
        end
        ST_CONVERT:
        begin
          if (event_done)
          begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign converting_reg = (state_reg != ST_IDLE);

  // ==================================================
  // Converter control zero register
  // ==================================================
  // Hardware sets of the flags win over a software clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      conv_ctrl_reg <= arg_pkg::CONV_CTRL_ZERO_RST;
    end
    else
    begin
      conv_ctrl_reg <= conv_wr_val;
      conv_ctrl_reg[arg_pkg::BUSY_BIT] <= converting_reg || start_now;
      if (event_done && state_reg == ST_CONVERT)
      begin
        conv_ctrl_reg[arg_pkg::DONE_FLAG_BIT] <= 1'b1;
        conv_ctrl_reg[arg_pkg::BUSY_BIT] <= 1'b0;
      end
      if (core_window_hit)
      begin
        conv_ctrl_reg[arg_pkg::WIN_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // ==================================================
  // Reference control register
  // ==================================================
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ref_ctrl_reg <= arg_pkg::REF_CTRL_RST;
    end
    else if (wr_ref)
    begin
      ref_ctrl_reg <= sfr_wdata;
    end
  end

  // ==================================================
  // Analog-side controls, all registered
  // ==================================================
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      analog_reg <= '0;
      temp_pos_reg <= 1'b0;
    end
    else
    begin
      // Selected source passes straight to the reference mux
      analog_reg.ref_source <= ref_ctrl_reg[arg_pkg::REF_SEL_LSB +: 2];
      analog_reg.iref_power <= ref_internal && converting_reg;
      analog_reg.iref_high <= ref_ctrl_reg[arg_pkg::IREF_LVL_BIT];
      analog_reg.temp_sensor_on <= ref_ctrl_reg[arg_pkg::TEMP_EN_BIT];
      temp_pos_reg <= temp_selected && single_ended;
      // Chip ground overrides: sensor sampling, or 1.65 V while converting outside tracking
      if ((temp_selected && core_tracking)
          || (ref_internal && !ref_ctrl_reg[arg_pkg::IREF_LVL_BIT]
              && converting_reg && !core_tracking))
      begin
        analog_reg.gnd_chip <= 1'b1;
        analog_reg.gnd_analog_pin <= 1'b0;
      end
      else
      begin
        analog_reg.gnd_chip <= 1'b0;
        analog_reg.gnd_analog_pin <= ref_ctrl_reg[arg_pkg::GND_SEL_BIT];
      end
    end
  end

  // ==================================================
  // Read port
  // ==================================================
  // Unmapped addresses read zero
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sfr_rdata_reg <= 8'h00;
    end
    else if (sfr_rd)
    begin
      case (sfr_addr)
        arg_pkg::CONV_CTRL_ZERO_ADDR: sfr_rdata_reg <= conv_ctrl_reg;
        arg_pkg::REF_CTRL_ADDR: sfr_rdata_reg <= ref_ctrl_reg;
        default: sfr_rdata_reg <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata = sfr_rdata_reg;
  assign conv_start = conv_start_reg;
  assign temp_to_positive = temp_pos_reg;
  assign analog_ctrl = analog_reg;

endmodule : arg_ref_ctrl

// file: design/arg_sync.sv
// Two-flop synchroniser with rising-edge pulse output
`timescale 1ns/100ps

module arg_sync
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic async_in,
  output logic rise_pulse
);

  // ==================================================
  // Synchroniser chain
  // ==================================================
  logic meta_reg;     // First stage, read only by the second stage
  logic sync_reg;     // Second stage, safe to use
  logic last_reg;     // Previous synchronised value for edge detect

  // Stages shift every edge; reset clears to constants
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // Edge detect works only on the settled stages
  assign rise_pulse = sync_reg & ~last_reg;

endmodule : arg_sync

// file: verif/arg_core_model.sv
// Behavioural model of the analog converter core behind the control block
`timescale 1ns/100ps

module arg_core_model
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic conv_start,
  input wire logic burst,
  input wire logic hit,
  output logic core_done,
  output logic core_burst_done,
  output logic core_tracking,
  output logic core_window_hit
);
  // ==================================================
  // Conversion timeline
  // ==================================================
  logic [3:0] cnt_reg; // Cycles left in the running conversion

  // A start launches three tracking cycles, then five converting cycles
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      cnt_reg <= 4'h0;
    else if (conv_start)
      cnt_reg <= 4'h8;
    else if (cnt_reg != 4'h0)
      cnt_reg <= cnt_reg - 4'h1;
  end

  // Done pulses last one cycle; burst mode reports the end of the burst too
  assign core_tracking = cnt_reg > 4'h5;
  assign core_done = cnt_reg == 4'h1;
  assign core_burst_done = core_done && burst;
  assign core_window_hit = core_done && hit;
endmodule : arg_core_model

// file: verif/arg_ref_ctrl_chk.sv
// Port-level assertion checker for the converter reference and ground control
`timescale 1ns/100ps

module arg_ref_ctrl_chk
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic temp_selected,
  input wire logic single_ended,
  input wire logic core_tracking,
  input wire logic [7:0] sfr_rdata,
  input wire logic conv_start,
  input wire logic temp_to_positive,
  input wire arg_pkg::arg_analog_s analog_ctrl
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ==================================================
  // Helper: last value written to the reference register
  // ==================================================
  logic ref_wr; // Byte write to the reference register
  logic [7:0] wd_reg; // Copy of the written value
  assign ref_wr = sfr_wr && sfr_addr == arg_pkg::REF_CTRL_ADDR;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      wd_reg <= 8'h00;
    else if (ref_wr)
      wd_reg <= sfr_wdata;
  end

  // One idle edge after the write allows for the two-cycle output latency
  sequence s_ref_wr;
    ref_wr ##1 !ref_wr;
  endsequence
  property p_ref_source;
    s_ref_wr |=> analog_ctrl.ref_source == wd_reg[4:3];
  endproperty
  a_ref_source: assert property (p_ref_source) else $error("reference source mismatch");
  property p_level;
    s_ref_wr |=> analog_ctrl.iref_high == wd_reg[5];
  endproperty
  a_level: assert property (p_level) else $error("reference level mismatch");
  property p_sensor;
    s_ref_wr |=> analog_ctrl.temp_sensor_on == wd_reg[0];
  endproperty
  a_sensor: assert property (p_sensor) else $error("sensor enable mismatch");
  property p_ground;
    s_ref_wr |=> analog_ctrl.gnd_chip || analog_ctrl.gnd_analog_pin == wd_reg[1];
  endproperty
  a_ground: assert property (p_ground) else $error("ground select mismatch");
  property p_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
  property p_iref;
    analog_ctrl.iref_power |-> analog_ctrl.ref_source == arg_pkg::REF_INTERNAL;
  endproperty
  a_iref: assert property (p_iref) else $error("reference powered while unused");
  property p_temp_gnd;
    temp_selected && core_tracking ##1 temp_selected && core_tracking |-> analog_ctrl.gnd_chip;
  endproperty
  a_temp_gnd: assert property (p_temp_gnd) else $error("sensor sampled off chip ground");
  // Powered low-level reference outside tracking must convert on chip ground
  property p_low_ref_gnd;
    analog_ctrl.iref_power && !analog_ctrl.iref_high && !$past(core_tracking)
      |-> analog_ctrl.gnd_chip;
  endproperty
  a_low_ref_gnd: assert property (p_low_ref_gnd) else $error("low level off chip ground");
  property p_temp_pos;
    temp_to_positive |-> $past(single_ended) && $past(temp_selected);
  endproperty
  a_temp_pos: assert property (p_temp_pos) else $error("sensor routed while differential");
  // Reset clears the start pulse, read data and analog controls; this one must not be disabled by reset
  property p_reset;
    disable iff (1'b0) !rst_n |=> !conv_start && sfr_rdata == 8'h00 && analog_ctrl == 7'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");

  c_start: cover property (conv_start);
  c_power: cover property (analog_ctrl.iref_power);
  c_chip: cover property (analog_ctrl.gnd_chip);
endmodule : arg_ref_ctrl_chk

bind arg_ref_ctrl arg_ref_ctrl_chk chk_u (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .temp_selected(temp_selected),
  .single_ended(single_ended), .core_tracking(core_tracking), .sfr_rdata(sfr_rdata),
  .conv_start(conv_start), .temp_to_positive(temp_to_positive), .analog_ctrl(analog_ctrl));

// file: verif/test_adc_reference_ground_select.sv
// Self-checking testbench for the converter reference and ground control
`timescale 1ns/100ps

module test_adc_reference_ground_select;
  logic clock = 1'h0, rst_n = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0, bit_wr = 1'h0;
  logic bit_val = 1'h0, temp_selected = 1'h0, single_ended = 1'h0, burst = 1'h0, hit = 1'h0;
  logic rd_d = 1'h0, seen_pwr = 1'h0, seen_chip = 1'h0; // Read pending, sticky observations
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00, rnd = 8'h4a, d, sfr_rdata;
  logic [3:0] tmr = 4'h0; // Timer 0, 2, 3 overflows and start pin
  logic conv_start, temp_to_positive, core_done, core_burst_done, core_tracking, core_window_hit;
  arg_pkg::arg_analog_s analog_ctrl;
  logic [7:0] exp_q[$]; // Expected read data, oldest first
  int n_fail = 0, tests_run = 0, n_start = 0, cyc = 0, ns0;

  always #12.5 clock = ~clock;

  arg_ref_ctrl #(.SETTLE_CYC(2)) dut_u (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .bit_wr(bit_wr), .bit_addr(bit_addr),
    .bit_val(bit_val), .timer0_ovf(tmr[0]), .timer2_ovf(tmr[1]), .timer3_ovf(tmr[2]),
    .external_start_pin(tmr[3]), .temp_selected(temp_selected), .single_ended(single_ended),
    .core_done(core_done), .core_burst_done(core_burst_done), .core_tracking(core_tracking),
    .core_window_hit(core_window_hit), .sfr_rdata(sfr_rdata), .conv_start(conv_start),
    .temp_to_positive(temp_to_positive), .analog_ctrl(analog_ctrl));
  arg_core_model core_u (.clock(clock), .rst_n(rst_n), .conv_start(conv_start), .burst(burst),
    .hit(hit), .core_done(core_done), .core_burst_done(core_burst_done),
    .core_tracking(core_tracking), .core_window_hit(core_window_hit));

  // ==================================================
  // Helpers
  // ==================================================
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  task automatic complete_run();
    $display("tests_run %0d n_fail %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  // Inputs always move 2 ns after the rising edge
  task automatic tick();
    @(posedge clock);
    #2;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'h1;
    tick();
    sfr_wr = 1'h0;
    tick();
  endtask : wr

  // The expectation is queued; the monitor compares when the data lands
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    sfr_addr = a;
    sfr_rd = 1'h1;
    tick();
    sfr_rd = 1'h0;
    tick();
  endtask : rd

  task automatic bitw(input logic [7:0] a);
    bit_addr = a;
    bit_val = 1'h1;
    bit_wr = 1'h1;
    tick();
    bit_wr = 1'h0;
    tick();
  endtask : bitw

  task automatic pulse(input logic [3:0] m);
    tmr = m;
    tick();
    tmr = 4'h0;
  endtask : pulse

  // Bounded wait for the end of a conversion, then let the flag land
  task automatic wait_done();
    for (int i = 0; i < 40 && core_done !== 1'h1; i++)
      tick();
    repeat (2) tick();
  endtask : wait_done

  // Monitor: read data, start count, sticky analog flags and the hang limit
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (rd_d)
      chk_val("sfr_rdata", exp_q.pop_front(), sfr_rdata);
    rd_d <= sfr_rd;
    n_start <= n_start + conv_start;
    seen_pwr <= rst_n && (seen_pwr || analog_ctrl.iref_power);
    seen_chip <= rst_n && (seen_chip || analog_ctrl.gnd_chip);
    if (cyc == 3000)
    begin
      n_fail++;
      complete_run();
    end
  end

  // ==================================================
  // Main sequence
  // ==================================================
  initial
  begin
    repeat (2) tick();
    rst_n = 1'h1;
    rd(arg_pkg::CONV_CTRL_ZERO_ADDR, 8'h00);
    rd(arg_pkg::REF_CTRL_ADDR, 8'h00);
    chk_val("analog_ctrl", 8'h00, {1'h0, analog_ctrl});
    $display("test reset done");
    for (int c = 0; c < 4; c++)
    begin
      rnd = lfsr(rnd);
      d = {rnd[7:5], c[1:0], rnd[2:0]};
      wr(arg_pkg::REF_CTRL_ADDR, d);
      rd(arg_pkg::REF_CTRL_ADDR, d);
      chk_val("ref_source", {6'h00, c[1:0]}, {6'h00, analog_ctrl.ref_source});
      chk_val("iref_high", {7'h00, d[5]}, {7'h00, analog_ctrl.iref_high});
      chk_val("gnd_pin", {7'h00, d[1]}, {7'h00, analog_ctrl.gnd_analog_pin});
      chk_val("temp_on", {7'h00, d[0]}, {7'h00, analog_ctrl.temp_sensor_on});
    end
    $display("test reference select done");
    wr(arg_pkg::REF_CTRL_ADDR, 8'h00);
    wr(arg_pkg::CONV_CTRL_ZERO_ADDR, 8'h90);
    wait_done();
    rd(arg_pkg::CONV_CTRL_ZERO_ADDR, 8'ha0);
    burst = 1'h1;
    hit = 1'h1;
    wr(arg_pkg::CONV_CTRL_ZERO_ADDR, 8'h50);
    wait_done();
    rd(arg_pkg::CONV_CTRL_ZERO_ADDR, 8'h68);
    burst = 1'h0;
    hit = 1'h0;
    wr(arg_pkg::CONV_CTRL_ZERO_ADDR, 8'h80);
    rd(arg_pkg::CONV_CTRL_ZERO_ADDR, 8'h80);
    chk_val("starts", 8'h02, n_start[7:0]);
    $display("test write start done");
    // Internal 1.65 V reference: powered only while converting, chip ground forced
    wr(arg_pkg::REF_CTRL_ADDR, 8'h18);
    wr(arg_pkg::CONV_CTRL_ZERO_ADDR, 8'h90);
    wait_done();
    chk_val("seen_pwr", 8'h01, {7'h00, seen_pwr});
    chk_val("iref_power", 8'h00, {7'h00, analog_ctrl.iref_power});
    chk_val("seen_chip", 8'h01, {7'h00, seen_chip});
    rd(arg_pkg::CONV_CTRL_ZERO_ADDR, 8'ha0);
    $display("test internal reference done");
    // Timer and pin start sources, wrong triggers first; reserved codes never start
    wr(arg_pkg::REF_CTRL_ADDR, 8'h20);
    for (int c = 1; c < 8; c++)
    begin
      wr(arg_pkg::CONV_CTRL_ZERO_ADDR, {5'h10, c[2:0]});
      ns0 = n_start;
      pulse(c < 5 ? ~(4'h1 << (c - 1)) : 4'hf);
      repeat (14) tick();
      chk_val("no_start", ns0[7:0], n_start[7:0]);
      if (c < 5)
      begin
        pulse(4'h1 << (c - 1));
        wait_done();
        chk_val("start", ns0[7:0] + 8'h01, n_start[7:0]);
        rd(arg_pkg::CONV_CTRL_ZERO_ADDR, {5'h14, c[2:0]});
      end
    end
    ns0 = n_start;
    wr(arg_pkg::CONV_CTRL_ZERO_ADDR, 8'h10);
    repeat (14) tick();
    chk_val("disabled", ns0[7:0], n_start[7:0]);
    $display("test start sources done");
    // Sensor routing and bit-addressed start with the sensor selected
    temp_selected = 1'h1;
    single_ended = 1'h1;
    repeat (2) tick();
    chk_val("temp_pos", 8'h01, {7'h00, temp_to_positive});
    wr(arg_pkg::CONV_CTRL_ZERO_ADDR, 8'h00);
    bitw(8'hef);
    bitw(8'hec);
    wait_done();
    rd(arg_pkg::CONV_CTRL_ZERO_ADDR, 8'ha0);
    single_ended = 1'h0;
    repeat (2) tick();
    chk_val("temp_pos", 8'h00, {7'h00, temp_to_positive});
    $display("test sensor done");
    complete_run();
  end
endmodule : test_adc_reference_ground_select
